// *** rtl/bmsd_defs.svh ***
// Purpose: Constants for the boot mode strap decoder
// Assumes: Straps are stable while power-on reset is asserted
// Notes: Timing counts assume the 4 ns clock
`ifndef BMSD_DEFS_SVH
`define BMSD_DEFS_SVH
`define BMSD_STRAP_W       5
`define BMSD_CFG_TIMEOUT_NS 1000
`define BMSD_CLK_NS        4
`define BMSD_CFG_TIMEOUT_CYC ((`BMSD_CFG_TIMEOUT_NS + `BMSD_CLK_NS - 1) / `BMSD_CLK_NS)
`define BMSD_SYNC_BANK     3'h4
`define BMSD_ASYNC_BANK    3'h0
`endif

// *** rtl/bmsd_pkg.sv ***
// Purpose: Types for the boot mode strap decoder
// Assumes: Included constants header
// Notes: Source codes are shared by decoder and top
package bmsd_pkg;
    typedef enum logic [3:0] {
        BMSD_SRC_NONE   = 4'h0,
        BMSD_SRC_NAND   = 4'h1,
        BMSD_SRC_XMODEM = 4'h2,
        BMSD_SRC_EEPROM = 4'h3,
        BMSD_SRC_AROM   = 4'h4,
        BMSD_SRC_SFLASH = 4'h5,
        BMSD_SRC_SROM   = 4'h6
    } bmsd_src_e;

    typedef struct packed {
        logic nand_width_strap;
        logic media_type_strap;
        logic bus_width_strap_hi;
        logic bus_width_strap_lo;
        logic internal_boot_strap;
    } bmsd_strap_s;

    typedef struct packed {
        bmsd_src_e   src;
        logic        internal;
        logic [5:0]  width_bits;
        logic [2:0]  addr_bytes;
        logic [2:0]  bank_at_zero;
        logic        undefined;
        logic        invalid;
    } bmsd_cfg_s;
endpackage : bmsd_pkg

// *** rtl/bmsd_decode.sv ***
// Purpose: Pure decode of latched straps into a boot configuration
// Assumes: Input is already latched and stable
// Notes: Combinational only
`timescale 1ns/10ps
`include "bmsd_defs.svh"
module bmsd_decode (
    input  wire bmsd_pkg::bmsd_strap_s strap_i,
    output bmsd_pkg::bmsd_cfg_s        cfg_o
);
    import bmsd_pkg::*;

    // Table decode; everything not assigned stays NONE
    always_comb begin
        logic [1:0] w;
        w   = {strap_i.bus_width_strap_hi, strap_i.bus_width_strap_lo};
        cfg_o              = '0;
        cfg_o.src          = BMSD_SRC_NONE;
        cfg_o.internal     = strap_i.internal_boot_strap;
        cfg_o.bank_at_zero = `BMSD_ASYNC_BANK;
        if (strap_i.internal_boot_strap) begin
            if (!strap_i.media_type_strap && w != 2'h3) begin
                cfg_o.src        = BMSD_SRC_NAND;
                cfg_o.width_bits = strap_i.nand_width_strap ? 6'h10 : 6'h08;
                cfg_o.addr_bytes = 3'h3 + {1'b0, w};
            end else if (!strap_i.nand_width_strap && strap_i.media_type_strap
                         && w == 2'h0) begin
                cfg_o.src        = BMSD_SRC_XMODEM;
            end else if (!strap_i.nand_width_strap && strap_i.media_type_strap
                         && w == 2'h1) begin
                cfg_o.src        = BMSD_SRC_EEPROM;
            end else begin
                cfg_o.undefined  = 1'b1;
            end
        end else if (!strap_i.media_type_strap) begin
            cfg_o.src = BMSD_SRC_AROM;
            if (w == 2'h0) begin
                cfg_o.width_bits = 6'h08;
            end else if (w == 2'h1) begin
                cfg_o.width_bits = 6'h10;
            end else if (w == 2'h2) begin
                cfg_o.width_bits = 6'h20;
            end else begin
                cfg_o.src     = BMSD_SRC_NONE;
                cfg_o.invalid = 1'b1;
            end
        end else begin
            cfg_o.src          = w[0] ? BMSD_SRC_SROM : BMSD_SRC_SFLASH;
            cfg_o.width_bits   = w[1] ? 6'h20 : 6'h10;
            cfg_o.bank_at_zero = `BMSD_SYNC_BANK;
        end
    end
endmodule : bmsd_decode

// *** rtl/bmsd_top.sv ***
// Purpose: Latch boot straps, decode boot source, hold processor until setup done or the setup wait times out
// Assumes: Straps stable during reset; sync controller reports setup completion
// Notes: Config request goes out for sync ROM always, for sync flash when enabled
`timescale 1ns/10ps
`include "bmsd_defs.svh"
module bmsd_top (
    input  wire logic                   clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   nand_width_strap_i,
    input  wire logic                   media_type_strap_i,
    input  wire logic                   bus_width_strap_hi_i,
    input  wire logic                   bus_width_strap_lo_i,
    input  wire logic                   internal_boot_strap_i,
    input  wire logic                   sflash_cfg_en_i,
    input  wire logic                   sync_cfg_done_i,
    output bmsd_pkg::bmsd_cfg_s         boot_cfg_o,
    output logic                        strap_valid_o,
    output logic                        sync_cfg_req_o,
    output logic                        cpu_release_o,
    output logic                        cfg_timeout_o
);
    import bmsd_pkg::*;

    typedef enum logic [1:0] {
        BMSD_ST_SAMPLE = 2'h0,
        BMSD_ST_DECODE = 2'h1,
        BMSD_ST_CONFIG = 2'h3,
        BMSD_ST_RUN    = 2'h2
    } bmsd_state_e;

    logic [4:0]  sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    bmsd_strap_s strap_ff, nxt_strap;
    bmsd_cfg_s   dec_cfg, cfg_ff, nxt_cfg;
    bmsd_state_e state_ff, nxt_state;
    logic [9:0]  tmo_ff, nxt_tmo;
    logic        tout_ff, nxt_tout;
    logic        need_cfg;

    // Pins cross into clock domain through two flops
    always_comb begin
        nxt_sync1 = {nand_width_strap_i, media_type_strap_i, bus_width_strap_hi_i,
                     bus_width_strap_lo_i, internal_boot_strap_i};
        nxt_sync2 = sync1_ff;
    end

    // No reset on the synchroniser: it keeps sampling while reset is held, so the
    // pins are through both stages by the time capture happens at release
    always_ff @(posedge clk_i) begin
        sync1_ff <= nxt_sync1;
        sync2_ff <= nxt_sync2;
    end

    bmsd_decode u_dec (
        .strap_i (strap_ff),
        .cfg_o   (dec_cfg)
    );

    // Flash gets setup only when enabled; ROM always needs it
    assign need_cfg = (cfg_ff.src == BMSD_SRC_SROM) ||
                      (cfg_ff.src == BMSD_SRC_SFLASH && sflash_cfg_en_i);

    // Sequencer: capture once, decode, configure, release
    always_comb begin
        nxt_state = state_ff;
        nxt_strap = strap_ff;
        nxt_cfg   = cfg_ff;
        nxt_tmo   = tmo_ff;
        nxt_tout  = tout_ff;
        case (state_ff)
            BMSD_ST_SAMPLE: begin
                nxt_strap = bmsd_strap_s'(sync2_ff);
                nxt_state = BMSD_ST_DECODE;
            end
            BMSD_ST_DECODE: begin
                nxt_cfg   = dec_cfg;
                nxt_state = BMSD_ST_CONFIG;
            end
            BMSD_ST_CONFIG: begin
                // Timeout stops a dead controller from hanging boot forever
                if (!need_cfg || sync_cfg_done_i) begin
                    nxt_state = BMSD_ST_RUN;
                end else if (tmo_ff == 10'(`BMSD_CFG_TIMEOUT_CYC)) begin
                    nxt_tout  = 1'b1;
                    nxt_state = BMSD_ST_RUN;
                end else begin
                    nxt_tmo = tmo_ff + 10'h001;
                end
            end
            default: begin
                nxt_state = BMSD_ST_RUN;
            end
        endcase
    end

    // Registers; strap and config never reload after leaving reset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap_ff <= '0;
            cfg_ff   <= '0;
            state_ff <= BMSD_ST_SAMPLE;
            tmo_ff   <= 10'h000;
            tout_ff  <= 1'b0;
        end else begin
            strap_ff <= nxt_strap;
            cfg_ff   <= nxt_cfg;
            state_ff <= nxt_state;
            tmo_ff   <= nxt_tmo;
            tout_ff  <= nxt_tout;
        end
    end

    // Outputs
    assign boot_cfg_o     = cfg_ff;
    assign strap_valid_o  = (state_ff == BMSD_ST_CONFIG) || (state_ff == BMSD_ST_RUN);
    assign sync_cfg_req_o = (state_ff == BMSD_ST_CONFIG) && need_cfg;
    assign cpu_release_o  = (state_ff == BMSD_ST_RUN);
    assign cfg_timeout_o  = tout_ff;

    AST_NO_RELEASE_BEFORE_CFG: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_ff == BMSD_ST_CONFIG && need_cfg && !sync_cfg_done_i && !tout_ff
         && tmo_ff != 10'(`BMSD_CFG_TIMEOUT_CYC)) |=> !cpu_release_o)
        else $error("Processor released before sync setup done");
    AST_HOLD_CFG: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cpu_release_o |=> $stable(boot_cfg_o) && cpu_release_o)
        else $error("Boot config changed after release");
    AST_SYNC_BANK: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        strap_valid_o && !boot_cfg_o.internal && boot_cfg_o.src inside
        {BMSD_SRC_SROM, BMSD_SRC_SFLASH} |-> boot_cfg_o.bank_at_zero == 3'h4)
        else $error("Sync boot not mapped to bank 4");
    AST_ASYNC_BANK: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        strap_valid_o && boot_cfg_o.src == BMSD_SRC_AROM
        |-> boot_cfg_o.bank_at_zero == 3'h0)
        else $error("Async boot not mapped to bank 0");
    AST_UNDEF_NONE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        strap_valid_o && boot_cfg_o.undefined |-> boot_cfg_o.src == BMSD_SRC_NONE)
        else $error("Undefined strap selected a source");
    AST_NAND_ADDR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        strap_valid_o && boot_cfg_o.src == BMSD_SRC_NAND
        |-> boot_cfg_o.addr_bytes == 3'h3 + {1'b0, strap_ff.bus_width_strap_hi,
        strap_ff.bus_width_strap_lo})
        else $error("NAND address length wrong");
    AST_NAND_WIDTH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        strap_valid_o && boot_cfg_o.src == BMSD_SRC_NAND
        |-> boot_cfg_o.width_bits == (strap_ff.nand_width_strap ? 6'h10 : 6'h08))
        else $error("NAND width wrong");
    AST_INTERNAL_SEL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        strap_valid_o |-> boot_cfg_o.internal == strap_ff.internal_boot_strap)
        else $error("Internal boot flag wrong");
    AST_SEQ_TIMING: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_ff == BMSD_ST_SAMPLE) |=> ##1 strap_valid_o)
        else $error("Decode did not complete in two cycles");

    // Longest setup wait: the counter end point plus the step into RUN
    localparam int cfg_wait_max = `BMSD_CFG_TIMEOUT_CYC + 1;

    // Boot steps as named sequences so the ordering checks read as a chain
    sequence bmsd_seq_capture;
        (state_ff == BMSD_ST_SAMPLE) ##1 (state_ff == BMSD_ST_DECODE);
    endsequence

    sequence bmsd_seq_setup_wait;
        sync_cfg_req_o && !sync_cfg_done_i && (tmo_ff != 10'(`BMSD_CFG_TIMEOUT_CYC));
    endsequence

    sequence bmsd_seq_setup_done;
        sync_cfg_req_o && sync_cfg_done_i;
    endsequence

    // Capture takes what the synchroniser holds, once per reset
    AST_STRAP_CAPTURE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_ff == BMSD_ST_SAMPLE) |=> strap_ff == $past(sync2_ff))
        else $error("Straps not taken from synchroniser");

    // Later pin activity must never reach the held straps
    AST_STRAP_FROZEN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_ff != BMSD_ST_SAMPLE) |=> $stable(strap_ff))
        else $error("Held straps changed after capture");

    // Decoded table entry is what gets registered for the memory controllers
    AST_DECODE_LATCH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_ff == BMSD_ST_DECODE) |=> boot_cfg_o == $past(dec_cfg))
        else $error("Decoded config not registered");

    // Straps reach the outputs two edges after capture starts
    AST_CAPTURE_ORDER: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        bmsd_seq_capture |=> (state_ff == BMSD_ST_CONFIG) && strap_valid_o)
        else $error("Capture steps out of order");

    // Request stays up while the controller is still busy and time is left
    AST_REQ_HOLDS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        bmsd_seq_setup_wait |=> sync_cfg_req_o)
        else $error("Setup request dropped early");

    // A completed setup releases the processor on the next edge
    AST_RELEASE_ON_DONE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        bmsd_seq_setup_done |=> cpu_release_o && !sync_cfg_req_o)
        else $error("Processor held after setup done");

    // A dead controller still lets the processor go, within the counted wait
    AST_SETUP_BOUND: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(sync_cfg_req_o) |-> ##[1:cfg_wait_max] cpu_release_o)
        else $error("Processor not released within the setup wait");

    // Timeout flag rises only once the full wait was counted
    AST_TIMEOUT_FLAG: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(cfg_timeout_o) |-> cpu_release_o
        && ($past(tmo_ff) == 10'(`BMSD_CFG_TIMEOUT_CYC)))
        else $error("Timeout flagged before the wait ran out");

    // Async ROM width doubles with each step of the width straps
    AST_ASYNC_WIDTH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        strap_valid_o && boot_cfg_o.src == BMSD_SRC_AROM
        |-> boot_cfg_o.width_bits == (6'h08 << {strap_ff.bus_width_strap_hi,
        strap_ff.bus_width_strap_lo}))
        else $error("Async ROM width wrong");

    // The forbidden external code must not pick any source
    AST_INVALID_NONE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        strap_valid_o && boot_cfg_o.invalid
        |-> boot_cfg_o.src == BMSD_SRC_NONE && !boot_cfg_o.internal)
        else $error("Invalid strap code selected a source");

    // Sync boot: upper strap gives the width, lower strap the device kind
    AST_SYNC_KIND: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        strap_valid_o && !boot_cfg_o.internal && strap_ff.media_type_strap
        |-> boot_cfg_o.width_bits == (strap_ff.bus_width_strap_hi ? 6'h20 : 6'h10)
        && boot_cfg_o.src == (strap_ff.bus_width_strap_lo ? BMSD_SRC_SROM
                                                          : BMSD_SRC_SFLASH))
        else $error("Sync boot width or kind wrong");

endmodule : bmsd_top

// *** dv/bmsd_board_model.sv ***
// Purpose: Board straps and sync memory controller stand-in
// Assumes: Bench sets straps before reset release
// Notes: Done comes a set wait after the request; a long wait forces timeout
`timescale 1ns/10ps
module bmsd_board_model (
    input  wire logic                  clk_i,
    input  wire logic                  req_i,
    input  wire bmsd_pkg::bmsd_strap_s want_i,
    input  wire logic [8:0]            delay_i,
    output bmsd_pkg::bmsd_strap_s      pins_o,
    output logic                       done_o
);
    import bmsd_pkg::*;
    logic [8:0] wait_ff;
    // Pins follow the board setting; the illegal combo only when bench asks
    assign pins_o = want_i;
    // Wait counter runs only while setup is wanted
    always_ff @(posedge clk_i) begin
        wait_ff <= req_i ? wait_ff + 9'h1 : 9'h0;
    end
    assign done_o = req_i && (wait_ff == delay_i);
endmodule : bmsd_board_model

// *** dv/boot_mode_strap_decoder_bench.sv ***
// Purpose: Self-checking bench for the boot mode strap decoder
// Assumes: Straps settled well before reset release
// Notes: Every strap code twice, random setup enable and done delay
`timescale 1ns/10ps
module boot_mode_strap_decoder_bench;
    import bmsd_pkg::*;
    logic        clk_i = 1'b0, rst_b_i = 1'b0, en = 1'b0;
    logic        req, rel, vld, tmo, done;
    bmsd_strap_s want = '0, pins;
    bmsd_cfg_s   cfg;
    logic [8:0]  dly = 9'h0;
    logic [31:0] lfsr = 32'h36268FDE;
    int          fails = 0, n_compared = 0, cyc = 0;
    always #2 clk_i = ~clk_i;
    bmsd_top bmsd_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .nand_width_strap_i(pins.nand_width_strap), .media_type_strap_i(pins.media_type_strap),
        .bus_width_strap_hi_i(pins.bus_width_strap_hi),
        .bus_width_strap_lo_i(pins.bus_width_strap_lo),
        .internal_boot_strap_i(pins.internal_boot_strap), .sflash_cfg_en_i(en),
        .sync_cfg_done_i(done), .boot_cfg_o(cfg), .strap_valid_o(vld),
        .sync_cfg_req_o(req), .cpu_release_o(rel), .cfg_timeout_o(tmo));
    bmsd_board_model bmsd_board_model_i (.clk_i(clk_i), .req_i(req), .want_i(want),
        .delay_i(dly), .pins_o(pins), .done_o(done));
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    // Four-state compare so an unknown never matches
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("Compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    // Hang guard: worst case is 64 runs of about 260 cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            report_and_stop();
        end
    end
    // One power-on boot with a given strap code
    task automatic run_one(input logic [4:0] code);
        int src, wb, ab, bank, inv, und, need, k;
        bmsd_strap_s s;
        s = code;
        lfsr = next_rand(lfsr);
        @(posedge clk_i);
        #1;
        rst_b_i = 1'b0;
        want = s;
        en = lfsr[0];
        dly = lfsr[1] ? 9'h12C : {4'h0, lfsr[6:2]};
        repeat (8) @(posedge clk_i);
        #1;
        chk("valid in reset", 0, vld);
        rst_b_i = 1'b1;
        src = BMSD_SRC_NONE; wb = 0; ab = 0; bank = 0; inv = 0; und = 0; need = 0;
        if (s.internal_boot_strap) begin
            if (!s.media_type_strap && code[2:1] != 2'b11) begin
                src = BMSD_SRC_NAND;
                wb = s.nand_width_strap ? 16 : 8;
                ab = 3 + code[2:1];
            end else if (s.media_type_strap && !s.nand_width_strap && !code[2])
                src = code[1] ? BMSD_SRC_EEPROM : BMSD_SRC_XMODEM;
            else und = 1;
        end else if (!s.media_type_strap) begin
            if (code[2:1] == 2'b11) inv = 1;
            else begin
                src = BMSD_SRC_AROM;
                wb = 8 << code[2:1];
            end
        end else begin
            src = code[1] ? BMSD_SRC_SROM : BMSD_SRC_SFLASH;
            wb = code[2] ? 32 : 16;
            bank = 4;
            need = code[1] | en;
        end
        k = 0;
        while (vld !== 1'b1 && k < 10) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        chk("valid delay", 2, k);
        chk("setup request", need, req);
        // Pins move one edge after the straps are valid, while setup may still be holding the processor
        @(posedge clk_i);
        #1;
        want = ~s;
        k = 0;
        while (rel !== 1'b1 && k < 400) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        chk("release", 1, rel);
        chk("timeout", need && dly == 9'h12C, tmo);
        chk("boot source", src, cfg.src);
        chk("internal", s.internal_boot_strap, cfg.internal);
        chk("undefined", und, cfg.undefined);
        chk("invalid", inv, cfg.invalid);
        if (src == BMSD_SRC_NAND || src >= BMSD_SRC_AROM) chk("width", wb, cfg.width_bits);
        if (src == BMSD_SRC_NAND) chk("address bytes", ab, cfg.addr_bytes);
        if (!s.internal_boot_strap && !inv) chk("bank", bank, cfg.bank_at_zero);
        $display("Test straps %0h done", code);
    endtask : run_one
    initial begin
        repeat (2) for (int c = 0; c < 32; c++) run_one(c[4:0]);
        report_and_stop();
    end
endmodule : boot_mode_strap_decoder_bench
